/* design/dtu_pkg.sv */
// Constants, register map and field layout of the dual timer unit.
// Assumes a 32-bit APB master and byte addresses on paddr.
package dtu_pkg;

    // ----------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------
    localparam int          ADDR_W      = 8;
    localparam logic [7:0]  OFF_CSR0    = 8'h00;
    localparam logic [7:0]  OFF_LOAD0   = 8'h04;
    localparam logic [7:0]  OFF_COUNT0  = 8'h08;
    localparam logic [7:0]  OFF_CSR1    = 8'h10;
    localparam logic [7:0]  OFF_LOAD1   = 8'h14;
    localparam logic [7:0]  OFF_COUNT1  = 8'h18;

    // ----------------------------------------
    // Control/status fields
    // ----------------------------------------
    localparam int          BIT_MODE    = 0;
    localparam int          BIT_DIR     = 1;
    localparam int          BIT_GEN     = 2;
    localparam int          BIT_CAPT    = 3;
    localparam int          BIT_RELOAD  = 4;
    localparam int          BIT_LOAD    = 5;
    localparam int          BIT_IRQEN   = 6;
    localparam int          BIT_ENABLE  = 7;
    localparam int          BIT_FLAG    = 8;
    localparam int          BIT_PWM     = 9;
    localparam int          BIT_ENALL   = 10;

    // ----------------------------------------
    // Reset values and timing
    // ----------------------------------------
    localparam logic [31:0] LOAD_RESET  = 32'h0000_0000;
    localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
    localparam int          NUM_CH      = 2;
    localparam int          ROLL_EXTRA  = 2;

    typedef struct packed {
        logic pwm_en;
        logic enable;
        logic irq_en;
        logic load;
        logic reload;
        logic capt_en;
        logic gen_en;
        logic dir;
        logic mode;
    } dtu_ctrl_s;

    localparam dtu_ctrl_s   CTRL_RESET  = '0;

endpackage

/* design/dtu_dual_timer.sv */
// Dual timer/counter with capture, pulse generation and paired PWM output.
// Assumes APB master on pclk; capture and freeze inputs synchronous to pclk.
`timescale 1ns/1ps

module dtu_dual_timer
    import dtu_pkg::*;
#(
    parameter int         CNT_W     = 32,
    parameter logic [1:0] PULSE_POL = 2'h3,
    parameter logic [1:0] CAPT_POL  = 2'h3
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              freeze,
    input  wire logic [1:0]        capture_in,
    output logic      [1:0]        interval_pulse_out,
    output logic                   pwm_output,
    output logic                   irq_out
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    localparam logic [CNT_W-1:0] CNT_ONES = '1;
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;

    dtu_ctrl_s [NUM_CH-1:0]  ctrl_r;
    logic [NUM_CH-1:0]       flag_r;
    logic                    enall_r;
    logic [CNT_W-1:0]        cnt_r   [NUM_CH];
    logic [CNT_W-1:0]        load_r  [NUM_CH];
    logic [NUM_CH-1:0]       done_r;
    logic [NUM_CH-1:0]       full_r;
    logic [NUM_CH-1:0]       cap_s_r;
    logic [NUM_CH-1:0]       cap_p_r;
    logic [NUM_CH-1:0]       pulse_r;
    logic [NUM_CH-1:0]       irq_r;
    logic                    pwm_r;
    logic [31:0]             prdata_r;

    logic [NUM_CH-1:0]       run;
    logic [NUM_CH-1:0]       roll;
    logic [NUM_CH-1:0]       cap_ev;
    logic [NUM_CH-1:0]       ev_nxt;
    logic [NUM_CH-1:0]       capt_wr;
    logic                    pwm_on;
    logic                    wr_acc;
    logic                    rd_acc;
    logic                    rd_setup;
    logic                    ch_sel;
    logic [1:0]              reg_sel;
    logic                    mapped;

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
        return (a[ADDR_W-1:5] == '0) && (a[1:0] == 2'h0) && (a[3:2] != 2'h3);
    endfunction

    function automatic logic [31:0] csr_word(input dtu_ctrl_s c, input logic f,
                                             input logic ea);
        logic [31:0] w;
        w              = 32'h0000_0000;
        w[BIT_MODE]    = c.mode;
        w[BIT_DIR]     = c.dir;
        w[BIT_GEN]     = c.gen_en;
        w[BIT_CAPT]    = c.capt_en;
        w[BIT_RELOAD]  = c.reload;
        w[BIT_LOAD]    = c.load;
        w[BIT_IRQEN]   = c.irq_en;
        w[BIT_ENABLE]  = c.enable;
        w[BIT_FLAG]    = f;
        w[BIT_PWM]     = c.pwm_en;
        w[BIT_ENALL]   = ea;
        return w;
    endfunction

    function automatic logic [31:0] widen(input logic [CNT_W-1:0] v);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[CNT_W-1:0] = v;
        return w;
    endfunction

    function automatic logic chan_hit(input logic [1:0] r, input logic [1:0] want,
                                      input logic c, input logic ch);
        return (r == want) && (c == ch);
    endfunction

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    assign ch_sel   = paddr[4];
    assign reg_sel  = paddr[3:2];
    assign mapped   = addr_ok(paddr);

    // ----------------------------------------
    // Access strobes
    // ----------------------------------------
    assign wr_acc   = psel && penable && pwrite && mapped;
    assign rd_acc   = psel && penable && !pwrite && mapped;
    assign rd_setup = psel && !penable && !pwrite;

    // ----------------------------------------
    // Bus handshake
    // ----------------------------------------
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !mapped;
    assign prdata   = prdata_r;

    // ----------------------------------------
    // Read data, loaded in setup phase
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
        end else if (rd_setup) begin
            if (!mapped) begin
                prdata_r <= 32'h0000_0000;
            end else begin
                unique case (reg_sel)
                    2'h0:    prdata_r <= csr_word(ctrl_r[ch_sel], flag_r[ch_sel], enall_r);
                    2'h1:    prdata_r <= widen(load_r[ch_sel]);
                    default: prdata_r <= widen(cnt_r[ch_sel]);
                endcase
            end
        end
    end

    // ----------------------------------------
    // Enable-all mirror
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enall_r <= 1'b0;
        end else if (wr_acc && reg_sel == 2'h0) begin
            enall_r <= pwdata[BIT_ENALL];
        end
    end

    // ----------------------------------------
    // PWM pairing
    // ----------------------------------------
    assign pwm_on = ctrl_r[0].pwm_en && ctrl_r[1].pwm_en;

    // ----------------------------------------
    // Channels
    // ----------------------------------------
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        logic csr_wr;
        logic load_wr;
        logic load_rd;
        logic restart;

        // ----------------------------------------
        // Register selects
        // ----------------------------------------
        assign csr_wr  = wr_acc && chan_hit(reg_sel, 2'h0, ch_sel, 1'(i));
        assign load_wr = wr_acc && chan_hit(reg_sel, 2'h1, ch_sel, 1'(i));
        assign load_rd = rd_acc && chan_hit(reg_sel, 2'h1, ch_sel, 1'(i));
        // ----------------------------------------
        // In PWM pairing, channel 1 restarts the cycle after channel 0 rolls
        // ----------------------------------------
        assign restart = (i == 1) && pwm_on && pulse_r[0];

        // ----------------------------------------
        // Counter runs on pclk directly, halted by freeze
        // ----------------------------------------
        assign run[i]  = ctrl_r[i].enable && !freeze && !ctrl_r[i].load
                         && !done_r[i] && !(pulse_r[i] && ctrl_r[i].reload);
        assign roll[i] = run[i] && !ctrl_r[i].mode
                         && (ctrl_r[i].dir ? cnt_r[i] == CNT_ZERO : cnt_r[i] == CNT_ONES);
        assign cap_ev[i] = cap_s_r[i] && !cap_p_r[i] && ctrl_r[i].mode
                           && ctrl_r[i].capt_en && ctrl_r[i].enable;
        assign ev_nxt[i] = roll[i] || cap_ev[i];
        assign capt_wr[i] = cap_ev[i] && (ctrl_r[i].reload || !full_r[i]);

        // ----------------------------------------
        // Control bits
        // ----------------------------------------
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                ctrl_r[i] <= CTRL_RESET;
            end else if (csr_wr) begin
                ctrl_r[i].mode    <= pwdata[BIT_MODE];
                ctrl_r[i].dir     <= pwdata[BIT_DIR];
                ctrl_r[i].gen_en  <= pwdata[BIT_GEN];
                ctrl_r[i].capt_en <= pwdata[BIT_CAPT];
                ctrl_r[i].reload  <= pwdata[BIT_RELOAD];
                ctrl_r[i].load    <= pwdata[BIT_LOAD];
                ctrl_r[i].irq_en  <= pwdata[BIT_IRQEN];
                ctrl_r[i].enable  <= pwdata[BIT_ENABLE] || pwdata[BIT_ENALL];
                ctrl_r[i].pwm_en  <= pwdata[BIT_PWM];
            end else if (wr_acc && reg_sel == 2'h0 && pwdata[BIT_ENALL]) begin
                ctrl_r[i].enable  <= 1'b1;
            end
        end

        // ----------------------------------------
        // Event flag, set beats clear
        // ----------------------------------------
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                flag_r[i] <= 1'b0;
            end else if (ev_nxt[i]) begin
                flag_r[i] <= 1'b1;
            end else if (csr_wr && pwdata[BIT_FLAG]) begin
                flag_r[i] <= 1'b0;
            end
        end

        // ----------------------------------------
        // Counter
        // ----------------------------------------
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cnt_r[i] <= COUNT_RESET[CNT_W-1:0];
            end else if (ctrl_r[i].load) begin
                cnt_r[i] <= load_r[i];
            end else if (restart) begin
                cnt_r[i] <= load_r[i];
            end else if (pulse_r[i] && ctrl_r[i].reload && !ctrl_r[i].mode) begin
                cnt_r[i] <= load_r[i];
            end else if (run[i]) begin
                cnt_r[i] <= ctrl_r[i].dir ? cnt_r[i] - 1'b1 : cnt_r[i] + 1'b1;
            end
        end

        // ----------------------------------------
        // Hold after rollover without reload
        // ----------------------------------------
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                done_r[i] <= 1'b0;
            end else if (ctrl_r[i].load || restart || ctrl_r[i].mode) begin
                done_r[i] <= 1'b0;
            end else if (roll[i] && !ctrl_r[i].reload) begin
                done_r[i] <= 1'b1;
            end
        end

        // ----------------------------------------
        // Load register: bus write or capture
        // ----------------------------------------
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                load_r[i] <= LOAD_RESET[CNT_W-1:0];
            end else if (capt_wr[i]) begin
                load_r[i] <= cnt_r[i];
            end else if (load_wr) begin
                load_r[i] <= pwdata[CNT_W-1:0];
            end
        end

        // ----------------------------------------
        // Captured value not yet read
        // ----------------------------------------
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                full_r[i] <= 1'b0;
            end else if (capt_wr[i]) begin
                full_r[i] <= 1'b1;
            end else if (load_rd || !ctrl_r[i].mode) begin
                full_r[i] <= 1'b0;
            end
        end

        // ----------------------------------------
        // Capture input sampling, normalised to active high
        // ----------------------------------------
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cap_s_r[i] <= 1'b0;
            end else begin
                cap_s_r[i] <= capture_in[i] ~^ CAPT_POL[i];
            end
        end

        // ----------------------------------------
        // Previous sample for edge detection
        // ----------------------------------------
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cap_p_r[i] <= 1'b0;
            end else begin
                cap_p_r[i] <= cap_s_r[i];
            end
        end

        // ----------------------------------------
        // Rollover pulse
        // ----------------------------------------
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                pulse_r[i] <= 1'b0;
            end else begin
                pulse_r[i] <= roll[i];
            end
        end

        // ----------------------------------------
        // Channel interrupt
        // ----------------------------------------
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                irq_r[i] <= 1'b0;
            end else begin
                irq_r[i] <= ev_nxt[i] && ctrl_r[i].irq_en;
            end
        end

        // ----------------------------------------
        // Gated and polarised pulse output
        // ----------------------------------------
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                interval_pulse_out[i] <= !PULSE_POL[i];
            end else begin
                interval_pulse_out[i] <= (roll[i] && ctrl_r[i].gen_en) ~^ PULSE_POL[i];
            end
        end
    end

    // ----------------------------------------
    // PWM output, set by channel 0 and cleared by channel 1 rollover
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_r <= 1'b0;
        end else if (!pwm_on) begin
            pwm_r <= 1'b0;
        end else if (roll[0] && ctrl_r[0].gen_en) begin
            pwm_r <= 1'b1;
        end else if (roll[1] && ctrl_r[1].gen_en) begin
            pwm_r <= 1'b0;
        end
    end

    assign pwm_output = pwm_r;

    // ----------------------------------------
    // Interrupt merge
    // ----------------------------------------
    assign irq_out    = |irq_r;

endmodule

/* test/dtu_dual_timer_properties.sv */
// Checker for the dual timer unit, bound to its top module.
// Assumes active-high pulses unless PULSE_POL says otherwise.
`timescale 1ns/1ps
module dtu_dual_timer_properties
    import dtu_pkg::*;
#(
    parameter logic [1:0] PULSE_POL = 2'h3
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              freeze,
    input wire logic [1:0]        interval_pulse_out,
    input wire logic              pwm_output,
    input wire logic              irq_out
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire       acc = psel && penable;
    wire [1:0] act = ~(interval_pulse_out ^ PULSE_POL);

    ready_always_a: assert property (pready)
        else $error("pready low");
    unmapped_err_a: assert property (acc && paddr[7:5] != 3'h0
        |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    mapped_ok_a: assert property (acc && paddr[7:5] == 3'h0 && paddr[1:0] == 2'h0
        && paddr[3:2] != 2'h3 |-> !pslverr)
        else $error("mapped access refused");
    idle_err_a: assert property (!acc |-> !pslverr)
        else $error("pslverr outside access");
    pulse_width_a: assert property (act != 2'h0 |=> (act & $past(act)) == 2'h0)
        else $error("pulse longer than one cycle");
    irq_width_a: assert property ($rose(irq_out) |=> !irq_out)
        else $error("irq longer than one cycle");
    freeze_quiet_a: assert property ($past(freeze) |-> act == 2'h0)
        else $error("pulse while frozen");
    reset_quiet_a: assert property ($rose(presetn) |-> !irq_out && !pwm_output && act == 2'h0)
        else $error("outputs active after reset");
endmodule

/* test/dtu_capture_src.sv */
// Far-side source of the capture inputs.
// Assumes fire pulses from the bench, synchronous to pclk.
`timescale 1ns/1ps
module dtu_capture_src #(
    parameter logic [1:0] CAPT_POL = 2'h3
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic [1:0]  fire,
    output logic     [1:0]  capture_in
);
    logic [1:0][2:0] cnt_r;
    // Hold each capture line active for four cycles
    always_ff @(posedge pclk or negedge presetn) begin
        for (int i = 0; i < 2; i++) begin
            if (!presetn) begin
                cnt_r[i] <= 3'h0;
            end else if (fire[i]) begin
                cnt_r[i] <= 3'h4;
            end else if (cnt_r[i] != 3'h0) begin
                cnt_r[i] <= cnt_r[i] - 3'h1;
            end
        end
    end
    assign capture_in = CAPT_POL ^ {cnt_r[1] == 3'h0, cnt_r[0] == 3'h0};
endmodule

/* test/tb_top.sv */
// Testbench for the dual timer unit over APB.
// Assumes default parameters: 32-bit counters, active-high levels.
`timescale 1ns/1ps
module tb_top;
    import dtu_pkg::*;
    logic              pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic              freeze = 0, err, pready, pslverr, pwm_output, irq_out;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0]       pwdata = '0, rd, prdata, ld, ctl;
    logic [1:0]        fire = 2'h0, capture_in, interval_pulse_out;
    int                miscompares = 0, checked = 0, cycles = 0, irqs = 0, p, q;

    dtu_dual_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .freeze(freeze), .capture_in(capture_in),
        .interval_pulse_out(interval_pulse_out), .pwm_output(pwm_output), .irq_out(irq_out));
    dtu_capture_src cap (.pclk(pclk), .presetn(presetn), .fire(fire), .capture_in(capture_in));

    // ----------------------------------------
    // Clock, timeout, tasks
    // ----------------------------------------
    always #2.5 pclk = ~pclk;
    always @(negedge pclk) if (irq_out === 1'b1) irqs++;
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            end_of_test();
        end
    end

    task end_of_test();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0; penable <= 0;
        @(posedge pclk);
    endtask
    task rdck(input logic [7:0] a, input logic [31:0] exp);
        apb(0, a, 32'h0);
        check(rd, exp);
    endtask
    task period(output int q);
        q = 0;
        do begin @(negedge pclk); q++; end while (interval_pulse_out[0] !== 1'b1 && q < 100);
    endtask
    task pwm_time(output int per, output int hi);
        hi = 0;
        @(negedge pclk);
        while (pwm_output !== 1'b0) @(negedge pclk);
        while (pwm_output !== 1'b1) @(negedge pclk);
        while (pwm_output === 1'b1) begin hi++; @(negedge pclk); end
        per = hi;
        while (pwm_output !== 1'b1) begin per++; @(negedge pclk); end
    endtask
    task fire1();
        fire <= 2'h2;
        @(posedge pclk);
        fire <= 2'h0;
        repeat (10) @(posedge pclk);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        rdck(OFF_CSR0, 32'h0);
        rdck(OFF_LOAD1, 32'h0);
        rdck(8'h0C, 32'h0);
        check(err, 1);
        rdck(8'h20, 32'h0);
        check(err, 1);
        for (int i = 0; i < 2; i++) begin
            ld = (i == 0) ? 32'h5 : 32'hFFFF_FFFA;
            ctl = (i == 0) ? 32'hD6 : 32'h94;
            apb(1, OFF_LOAD0, ld);
            apb(1, OFF_CSR0, (ctl & 32'h12) | 32'h20);
            apb(1, OFF_CSR0, ctl);
            period(p);
            irqs = 0;
            period(p);
            check(p, ctl[1] ? ld + 2 : 32'hFFFF_FFFF - ld + 2);
            check(irqs != 0, ctl[6]);
            apb(1, OFF_CSR0, ctl & 32'h7F);
            rdck(OFF_CSR0, (ctl & 32'h7F) | 32'h100);
            apb(1, OFF_CSR0, 32'h100);
            rdck(OFF_CSR0, 32'h0);
        end
        apb(1, OFF_LOAD0, 32'h3);
        apb(1, OFF_CSR0, 32'h22);
        apb(1, OFF_CSR0, 32'h86);
        period(p);
        period(p);
        check(p, 100);
        apb(1, OFF_CSR0, 32'h100);
        apb(1, OFF_LOAD0, 32'h9);
        apb(1, OFF_LOAD1, 32'h3);
        apb(1, OFF_CSR0, 32'h32);
        apb(1, OFF_CSR1, 32'h22);
        apb(1, OFF_CSR0, 32'h296);
        apb(1, OFF_CSR1, 32'h286);
        repeat (30) @(posedge pclk);
        pwm_time(p, q);
        check(q, 32'h3 + 2);
        check(p, 32'h9 + 2);
        apb(1, OFF_CSR1, 32'h100);
        @(negedge pclk);
        check(pwm_output, 0);
        apb(1, OFF_CSR0, 32'h100);
        apb(1, OFF_LOAD1, 32'h1234);
        apb(1, OFF_CSR1, 32'h20);
        freeze <= 1;
        apb(1, OFF_CSR1, 32'h49);
        fire1();
        rdck(OFF_CSR1, 32'h49);
        apb(1, OFF_LOAD1, 32'h55);
        apb(1, OFF_CSR1, 32'hC9);
        fire1();
        rdck(OFF_CSR1, 32'h1C9);
        freeze <= 0;
        fire1();
        freeze <= 1;
        rdck(OFF_LOAD1, 32'h1234);
        apb(1, OFF_LOAD1, 32'h77);
        apb(1, OFF_CSR1, 32'h20);
        apb(1, OFF_CSR1, 32'hD9);
        fire1();
        freeze <= 0;
        fire1();
        rdck(OFF_LOAD1, 32'h79);
        end_of_test();
    end
endmodule

bind dtu_dual_timer dtu_dual_timer_properties #(.PULSE_POL(PULSE_POL)) chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .freeze(freeze),
    .interval_pulse_out(interval_pulse_out), .pwm_output(pwm_output), .irq_out(irq_out));
